// File: inc/dcr_pkg.sv
// Package for the line control register bank: offsets, fields, resets, timing
package dcr_pkg;

   // Register indices on the register port
   localparam logic [5:0] LINE_CONTROL_A_IDX = 6'h01;
   localparam logic [5:0] LINE_CONTROL_B_IDX = 6'h02;
   localparam logic [5:0] OFFHOOK_CTL_IDX    = 6'h05;  // Off-hook control register
   localparam logic [5:0] RING_FLAG_IDX      = 6'h04;  // Interrupt source register
   localparam logic [5:0] RING_MASK_IDX      = 6'h03;  // Interrupt mask register

   // Field positions in line_control_a
   localparam int OUTPUT_MODULATION_ENABLE_POS = 3;
   localparam int BARRIER_LOOPBACK_POS         = 1;
   // Field positions in line_control_b
   localparam int IRQ_PIN_SELECT_POS     = 7;
   localparam int IRQ_POLARITY_POS       = 6;
   localparam int ACCESS_WATCHDOG_ON_POS = 4;
   localparam int RING_IRQ_MODE_POS      = 2;
   localparam int HYBRID_CONNECT_POS     = 1;
   localparam int RX_PATH_ON_POS         = 0;
   // Positions in the other registers
   localparam int OFFHOOK_CTL_POS    = 0;
   localparam int RING_FLAG_POS      = 7;
   localparam int RING_FLAG_MASK_POS = 7;

   // Writable bit masks; everything else reads zero
   localparam logic [7:0] LINE_CONTROL_A_WMASK = 8'h0a;
   localparam logic [7:0] LINE_CONTROL_B_WMASK = 8'hd7;

   // Reset values
   localparam logic [7:0] LINE_CONTROL_A_RST = 8'h00;
   localparam logic [7:0] LINE_CONTROL_B_RST = 8'h00;

   // Watchdog timeout
   localparam longint WDOG_TIMEOUT_MS = 4000;
   localparam longint CLK_HZ          = 100000000;
   localparam longint WDOG_CYCLES     = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int     WDOG_W          = 29;
   localparam int     PWM_W           = 8;

   // Register port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } dcr_req_t;

   // Ring detector tracking states
   typedef enum logic [1:0] {
      DCR_RING_IDLE,
      DCR_RING_BURST,
      DCR_RING_ARMED
   } dcr_ring_state_t;

endpackage

// File: verilog/dcr_watchdog.sv
// Register-access watchdog that times out after a long idle period
`timescale 1ns/100ps
module dcr_watchdog #(
   parameter logic [28:0] TIMEOUT = 29'(dcr_pkg::WDOG_CYCLES)
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic resetn_i,
   // Control
   input  wire logic enable_i,
   input  wire logic kick_i,
   // Status
   output logic      expire_o
);

   logic [28:0] count_reg;
   logic [28:0] count_next;
   wire         at_end = (count_reg == TIMEOUT - 29'h1);

   // Any access restarts from zero; count holds at end while idle
   assign count_next = (!enable_i || kick_i) ? 29'h0 :
                       at_end ? count_reg : count_reg + 29'h1;
   assign expire_o   = enable_i && !kick_i && (count_reg == TIMEOUT - 29'h2);

   // Counter register
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         count_reg <= 29'h0;
      else
         count_reg <= count_next;
   end

endmodule

// File: verilog/dcr_pwm.sv
// First-order sigma-delta modulator producing a one-bit stream from audio
`timescale 1ns/100ps
module dcr_pwm (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      resetn_i,
   // Audio in, unsigned offset code
   input  wire logic                      enable_i,
   input  wire logic [dcr_pkg::PWM_W-1:0] level_i,
   // Bit stream
   output logic                           bit_o
);

   logic [dcr_pkg::PWM_W:0] acc_reg;
   logic [dcr_pkg::PWM_W:0] acc_next;

   // Carry out of the accumulator is the output bit; density tracks level
   assign acc_next = {1'b0, acc_reg[dcr_pkg::PWM_W-1:0]} + {1'b0, level_i};

   // Accumulator and output flop, cleared while disabled
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         acc_reg <= '0;
         bit_o   <= 1'b0;
      end
      else if (!enable_i)
      begin
         acc_reg <= '0;
         bit_o   <= 1'b0;
      end
      else
      begin
         acc_reg <= acc_next;
         bit_o   <= acc_next[dcr_pkg::PWM_W];
      end
   end

endmodule

// File: verilog/dcr_line_control.sv
// Operation
// - Modulation enable gates summed-audio bit stream
// - Loopback bit loops data through filters
// - Select bit picks progress or irq pin
// - Polarity bit sets irq active level
// - Watchdog enable sticks until hardware reset
// - Idle four seconds clears off-hook control
// - Any register access restarts watchdog
// - Setting off-hook again restores off-hook
// - Mode 0: interrupt at burst start
// - Mode 1: also at end, if cleared
// - Hybrid bit inserts echo hybrid
// - Receive enable switches receive path
// - Ring flag sticky; irq needs mask, select
`timescale 1ns/100ps
module dcr_line_control #(
   parameter logic [28:0] WDOG_TIMEOUT = 29'(dcr_pkg::WDOG_CYCLES)
) (
   // Clock and reset
   input  wire logic                         CLK_I,
   input  wire logic                         RESETN_I,
   // Register port
   input  wire dcr_pkg::dcr_req_t            REQ_I,
   output logic [7:0]                        RDATA_O,
   // Line events and audio
   input  wire logic                         RING_ACTIVE_I,
   input  wire logic [dcr_pkg::PWM_W-1:0]    TX_AUDIO_I,
   input  wire logic [dcr_pkg::PWM_W-1:0]    RX_AUDIO_I,
   // Data path steering
   output logic                              BARRIER_LOOPBACK_O,
   output logic                              HYBRID_CONNECT_O,
   output logic                              RX_PATH_ON_O,
   output logic                              OFFHOOK_CTL_O,
   // Shared pin: modulated output or interrupt request
   output logic                              PROGRESS_OR_IRQ_PIN_O,
   output logic                              PROGRESS_ACTIVE_O
);

   logic [7:0]                  ctl_a_reg;
   logic [7:0]                  ctl_b_reg;
   logic                        offhook_reg;
   logic                        ring_flag_reg;
   logic                        ring_mask_reg;
   logic                        ring_d_reg;
   logic                        pin_reg;
   logic [7:0]                  ctl_b_next;
   logic                        ring_flag_next;
   logic                        offhook_next;
   logic                        pin_next;
   dcr_pkg::dcr_ring_state_t    ring_st_reg;
   dcr_pkg::dcr_ring_state_t    ring_st_next;
   logic [7:0]                  rdata_next;

   // Access decode
   wire access   = REQ_I.rd | REQ_I.wr;
   wire wr_a     = REQ_I.wr && (REQ_I.addr == dcr_pkg::LINE_CONTROL_A_IDX);
   wire wr_b     = REQ_I.wr && (REQ_I.addr == dcr_pkg::LINE_CONTROL_B_IDX);
   wire wr_oh    = REQ_I.wr && (REQ_I.addr == dcr_pkg::OFFHOOK_CTL_IDX);
   wire wr_flag  = REQ_I.wr && (REQ_I.addr == dcr_pkg::RING_FLAG_IDX);
   wire wr_mask  = REQ_I.wr && (REQ_I.addr == dcr_pkg::RING_MASK_IDX);

   // Field views
   wire pwm_en   = ctl_a_reg[dcr_pkg::OUTPUT_MODULATION_ENABLE_POS];
   wire irq_sel  = ctl_b_reg[dcr_pkg::IRQ_PIN_SELECT_POS];
   wire irq_pol  = ctl_b_reg[dcr_pkg::IRQ_POLARITY_POS];
   wire wdog_on  = ctl_b_reg[dcr_pkg::ACCESS_WATCHDOG_ON_POS];
   wire ring_mod = ctl_b_reg[dcr_pkg::RING_IRQ_MODE_POS];

   wire ring_rise = RING_ACTIVE_I && !ring_d_reg;
   wire ring_fall = !RING_ACTIVE_I && ring_d_reg;
   wire wdog_expire;
   wire pwm_bit;

   dcr_watchdog #(
      .TIMEOUT  (WDOG_TIMEOUT)
   ) u_wdog (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .enable_i (wdog_on),
      .kick_i   (access),
      .expire_o (wdog_expire)
   );

   // Sum of transmit and receive audio, halved to stay in range
   wire [dcr_pkg::PWM_W:0] audio_sum = {1'b0, TX_AUDIO_I} + {1'b0, RX_AUDIO_I};

   dcr_pwm u_pwm (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .enable_i (pwm_en && !irq_sel),
      .level_i  (audio_sum[dcr_pkg::PWM_W:1]),
      .bit_o    (pwm_bit)
   );

   // Watchdog enable can be set but not cleared by writes
   assign ctl_b_next = wr_b ?
      ((REQ_I.wdata & dcr_pkg::LINE_CONTROL_B_WMASK) |
       (ctl_b_reg & (8'h01 << dcr_pkg::ACCESS_WATCHDOG_ON_POS))) : ctl_b_reg;

   // Timeout clears off-hook; a later write restores it
   assign offhook_next = wr_oh ? REQ_I.wdata[dcr_pkg::OFFHOOK_CTL_POS] :
                         wdog_expire ? 1'b0 : offhook_reg;

   // Ring tracking: start always flags; end flags only in mode 1 after service
   always_comb
   begin
      ring_st_next = ring_st_reg;
      case (ring_st_reg)
         dcr_pkg::DCR_RING_IDLE:
            if (ring_rise)
               ring_st_next = dcr_pkg::DCR_RING_BURST;
         dcr_pkg::DCR_RING_BURST:
            if (ring_fall)
               ring_st_next = dcr_pkg::DCR_RING_IDLE;
            else if (wr_flag && !REQ_I.wdata[dcr_pkg::RING_FLAG_POS])
               ring_st_next = dcr_pkg::DCR_RING_ARMED;
         dcr_pkg::DCR_RING_ARMED:
            if (ring_fall)
               ring_st_next = dcr_pkg::DCR_RING_IDLE;
         default:
            ring_st_next = dcr_pkg::DCR_RING_IDLE;
      endcase
   end

   // Start of burst sets flag; end in mode 1 when armed
   wire ring_end_ev = ring_fall && ring_mod && (ring_st_reg == dcr_pkg::DCR_RING_ARMED);
   wire ring_event  = ring_rise || ring_end_ev;

   // Sticky flag, writing 0 clears, new event wins over clear
   assign ring_flag_next = ring_event ? 1'b1 :
                           (wr_flag && !REQ_I.wdata[dcr_pkg::RING_FLAG_POS]) ? 1'b0 :
                           ring_flag_reg;

   // Request needs both mask and pin select
   wire irq_req = ring_flag_reg && ring_mask_reg && irq_sel;

   // Pin function select; polarity applied in interrupt mode
   assign pin_next = irq_sel ? (irq_req ~^ irq_pol) : (pwm_en && pwm_bit);

   // Read mux, reserved bits and unmapped addresses read zero
   always_comb
   begin
      rdata_next = 8'h00;
      case (REQ_I.addr)
         dcr_pkg::LINE_CONTROL_A_IDX: rdata_next = ctl_a_reg;
         dcr_pkg::LINE_CONTROL_B_IDX: rdata_next = ctl_b_reg;
         dcr_pkg::OFFHOOK_CTL_IDX:
            rdata_next[dcr_pkg::OFFHOOK_CTL_POS] = offhook_reg;
         dcr_pkg::RING_FLAG_IDX:
            rdata_next[dcr_pkg::RING_FLAG_POS] = ring_flag_reg;
         dcr_pkg::RING_MASK_IDX:
            rdata_next[dcr_pkg::RING_FLAG_MASK_POS] = ring_mask_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Control registers
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ctl_a_reg <= dcr_pkg::LINE_CONTROL_A_RST;
         ctl_b_reg <= dcr_pkg::LINE_CONTROL_B_RST;
         offhook_reg <= 1'b0;
         ring_mask_reg <= 1'b0;
      end
      else
      begin
         if (wr_a)
            ctl_a_reg <= REQ_I.wdata & dcr_pkg::LINE_CONTROL_A_WMASK;
         ctl_b_reg <= ctl_b_next;
         offhook_reg <= offhook_next;
         if (wr_mask)
            ring_mask_reg <= REQ_I.wdata[dcr_pkg::RING_FLAG_MASK_POS];
      end
   end

   // Ring state, flag and output flops
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ring_st_reg <= dcr_pkg::DCR_RING_IDLE;
         ring_flag_reg <= 1'b0;
         ring_d_reg <= 1'b0;
         pin_reg <= 1'b0;
         RDATA_O <= 8'h00;
      end
      else
      begin
         ring_st_reg <= ring_st_next;
         ring_flag_reg <= ring_flag_next;
         ring_d_reg <= RING_ACTIVE_I;
         pin_reg <= pin_next;
         if (REQ_I.rd)
            RDATA_O <= rdata_next;
      end
   end

   // Steering bits go straight to the data path
   assign BARRIER_LOOPBACK_O    = ctl_a_reg[dcr_pkg::BARRIER_LOOPBACK_POS];
   assign HYBRID_CONNECT_O      = ctl_b_reg[dcr_pkg::HYBRID_CONNECT_POS];
   assign RX_PATH_ON_O          = ctl_b_reg[dcr_pkg::RX_PATH_ON_POS];
   assign OFFHOOK_CTL_O         = offhook_reg;
   assign PROGRESS_OR_IRQ_PIN_O = pin_reg;
   // Loopback relies on the host having the line side up and off-hook first
   assign PROGRESS_ACTIVE_O     = !irq_sel && pwm_en;

endmodule

// File: tb/dcr_assertions.sv
// Port checker for the line control register bank
`timescale 1ns/100ps
module dcr_assertions #(
   parameter logic [28:0] WDOG_TIMEOUT = 29'(dcr_pkg::WDOG_CYCLES)
) (
   // Clock, reset and register port
   input  wire logic              CLK_I,
   input  wire logic              RESETN_I,
   input  wire dcr_pkg::dcr_req_t REQ_I,
   input  wire logic [7:0]        RDATA_O,
   // Control outputs
   input  wire logic              BARRIER_LOOPBACK_O,
   input  wire logic              HYBRID_CONNECT_O,
   input  wire logic              RX_PATH_ON_O,
   input  wire logic              OFFHOOK_CTL_O,
   input  wire logic              PROGRESS_ACTIVE_O
);
   logic wdog_on_reg;
   int   idle_reg;
   wire  any_access = REQ_I.rd | REQ_I.wr;
   wire  wr_b       = REQ_I.wr && REQ_I.addr == dcr_pkg::LINE_CONTROL_B_IDX;

   // Watchdog arming and idle length; a margin of 2 absorbs the expiry edge
   always_ff @(posedge CLK_I or negedge RESETN_I)
      if (!RESETN_I)
      begin
         wdog_on_reg <= 1'b0;
         idle_reg    <= 0;
      end
      else
      begin
         if (wr_b && REQ_I.wdata[4])
            wdog_on_reg <= 1'b1;
         idle_reg <= any_access ? 0 : idle_reg + 1;
      end

   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   // Register port transfers
   sequence wr_a_s; REQ_I.wr && REQ_I.addr == dcr_pkg::LINE_CONTROL_A_IDX; endsequence
   sequence rd_a_s; REQ_I.rd && REQ_I.addr == dcr_pkg::LINE_CONTROL_A_IDX; endsequence
   sequence rd_b_s; REQ_I.rd && REQ_I.addr == dcr_pkg::LINE_CONTROL_B_IDX; endsequence

   loopback_follow_a: assert property (wr_a_s |=> BARRIER_LOOPBACK_O == $past(REQ_I.wdata[1]))
      else $error("loopback output does not follow write");
   hybrid_follow_a: assert property (wr_b |=> HYBRID_CONNECT_O == $past(REQ_I.wdata[1]))
      else $error("hybrid output does not follow write");
   rx_follow_a: assert property (wr_b |=> RX_PATH_ON_O == $past(REQ_I.wdata[0]))
      else $error("receive path output does not follow write");
   rsvd_a_zero_a: assert property (rd_a_s |=> (RDATA_O & 8'hf5) == 8'h00)
      else $error("reserved bits of control a read nonzero");
   rsvd_b_zero_a: assert property (rd_b_s |=> (RDATA_O & 8'h28) == 8'h00)
      else $error("reserved bits of control b read nonzero");
   wdog_sticky_a: assert property (rd_b_s ##0 wdog_on_reg |=> RDATA_O[4])
      else $error("watchdog enable bit was cleared");
   wdog_expire_a: assert property (wdog_on_reg && idle_reg > WDOG_TIMEOUT + 2 |-> !OFFHOOK_CTL_O)
      else $error("off-hook survived watchdog timeout");
   offhook_set_a: assert property (REQ_I.wr && REQ_I.addr == dcr_pkg::OFFHOOK_CTL_IDX
      && REQ_I.wdata[0] |=> OFFHOOK_CTL_O)
      else $error("off-hook write not honoured");
   irq_select_a: assert property (wr_b && REQ_I.wdata[7] |=> !PROGRESS_ACTIVE_O)
      else $error("modulated output active in interrupt mode");
   pwm_off_a: assert property (wr_a_s ##0 !REQ_I.wdata[3] |=> !PROGRESS_ACTIVE_O)
      else $error("modulated output active while disabled");
endmodule

// File: tb/testbench.sv
// Self-checking bench for the line control register bank
`timescale 1ns/100ps
module testbench;
   localparam logic [28:0] WDOG_TIMEOUT = 29'd50;  // Short timeout keeps the run brief
   localparam logic [5:0]  RA = dcr_pkg::LINE_CONTROL_A_IDX;
   localparam logic [5:0]  RB = dcr_pkg::LINE_CONTROL_B_IDX;
   logic              clk, resetn, ring, lpbk, hyb, rxon, offh, pin, pact;
   logic [7:0]        tx, rx, rdata, d;
   dcr_pkg::dcr_req_t req;
   int                error_cnt, num_checks, cyc, n;

   dcr_line_control #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) i_dcr_line_control (.CLK_I(clk),
      .RESETN_I(resetn), .REQ_I(req), .RDATA_O(rdata), .RING_ACTIVE_I(ring), .TX_AUDIO_I(tx),
      .RX_AUDIO_I(rx), .BARRIER_LOOPBACK_O(lpbk), .HYBRID_CONNECT_O(hyb), .RX_PATH_ON_O(rxon),
      .OFFHOOK_CTL_O(offh), .PROGRESS_OR_IRQ_PIN_O(pin), .PROGRESS_ACTIVE_O(pact));

   // Bus cycles, waits and comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic set_ring(input logic v);
      @(posedge clk);
      ring <= v;
      idle(3);  // Flag one edge, pin the next
   endtask
   // Counts ones on the shared pin over 32 cycles
   task automatic ones();
      n = 0;
      repeat (32)
      begin
         idle(1);
         n += int'(pin);
      end
   endtask

   task automatic test_ctl_a();
      rd(RA); chk(d, 8'h00);                  // reset value
      wr(dcr_pkg::OFFHOOK_CTL_IDX, 8'h01);    // off-hook before loopback
      idle(1); chk({7'h0, offh}, 8'h01);      // line is off-hook
      wr(RA, 8'hff); rd(RA); chk(d, 8'h0a);   // reserved read zero
      chk({6'h0, lpbk, pact}, 8'h03);         // loopback and modulation on
      ones(); chk({7'h0, n != 0}, 8'h01);     // bit stream runs
      wr(RA, 8'h00); idle(1); chk({7'h0, lpbk}, 8'h00); // loopback off
      ones(); chk({7'h0, n != 0}, 8'h00);     // pin quiet
   endtask
   task automatic test_ctl_b();
      rd(RB); chk(d, 8'h00);                  // reset value
      wr(RB, 8'hff); rd(RB); chk(d, 8'hd7);   // reserved read zero
      chk({5'h0, hyb, rxon, pact}, 8'h06);    // paths on, pin is irq
      wr(RB, 8'h00); rd(RB); chk(d, 8'h10);   // watchdog bit sticks
      chk({6'h0, hyb, rxon}, 8'h00);          // paths off
   endtask
   task automatic test_ring();
      wr(dcr_pkg::RING_MASK_IDX, 8'h80);
      wr(RB, 8'h90); wr(dcr_pkg::RING_FLAG_IDX, 8'h00); idle(2);
      chk({7'h0, pin}, 8'h01);                // active low idles high
      set_ring(1'b1); chk({7'h0, pin}, 8'h00); // start interrupt
      rd(dcr_pkg::RING_FLAG_IDX); chk({7'h0, d[7]}, 8'h01); // flag set
      wr(dcr_pkg::RING_FLAG_IDX, 8'h00); set_ring(1'b0);
      chk({7'h0, pin}, 8'h01);                // no end interrupt
      wr(RB, 8'hd4); idle(2); chk({7'h0, pin}, 8'h00); // active high idles low
      set_ring(1'b1); chk({7'h0, pin}, 8'h01); // start interrupt
      wr(dcr_pkg::RING_FLAG_IDX, 8'h00); idle(2); chk({7'h0, pin}, 8'h00); // cleared
      set_ring(1'b0); chk({7'h0, pin}, 8'h01); // end interrupt
      wr(dcr_pkg::RING_MASK_IDX, 8'h00); idle(2); chk({7'h0, pin}, 8'h00); // masked
   endtask
   task automatic test_wdog();
      wr(dcr_pkg::OFFHOOK_CTL_IDX, 8'h01); idle(2);
      repeat (3)
      begin
         idle(40); rd(RA); chk({7'h0, offh}, 8'h01); // access restarts count
      end
      idle(60); chk({7'h0, offh}, 8'h00);     // timeout goes on-hook
      wr(dcr_pkg::OFFHOOK_CTL_IDX, 8'h01); idle(2); chk({7'h0, offh}, 8'h01);
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard; the whole sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   // Main sequence
   initial
   begin
      resetn = 1'b0; req = '0; ring = 1'b0; tx = 8'h40; rx = 8'h20;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      test_ctl_a(); test_ctl_b(); test_ring(); test_wdog();
      complete_run();
   end
endmodule

bind dcr_line_control dcr_assertions #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) i_dcr_assertions (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
   .BARRIER_LOOPBACK_O(BARRIER_LOOPBACK_O), .HYBRID_CONNECT_O(HYBRID_CONNECT_O),
   .RX_PATH_ON_O(RX_PATH_ON_O), .OFFHOOK_CTL_O(OFFHOOK_CTL_O),
   .PROGRESS_ACTIVE_O(PROGRESS_ACTIVE_O));
